// *** kbt_consts.svh ***
// Constants for the keyboard and interval timer port.
// Assumes a 100 MHz system clock; included by bare name.
`ifndef KBT_CONSTS_SVH
`define KBT_CONSTS_SVH
// ----------------------------------------
// Select code and status / control bits
// ----------------------------------------
`define KBT_SEL_CODE 8'hE1
`define KBT_ST_AVAIL 7
`define KBT_ST_TIMEOUT 6
`define KBT_ST_PARITY 5
`define KBT_PC_IRQ_EN 7
`define KBT_PC_EVEN 6
`define KBT_PC_HALT_IOP 5
`define KBT_PC_BLOCK_DISP 4
// ----------------------------------------
// Key code bases
// ----------------------------------------
`define KBT_LOWER_BASE 8'h61
`define KBT_UPPER_BASE 8'h41
`define KBT_CTRL_BASE 8'h01
`define KBT_CPAD_BASE 8'h80
`define KBT_CPAD_SHIFT 8'h10
`define KBT_FKEY_BASE 8'hE0
`define KBT_PROGRAM_LOAD_KEY_IDX 5'h0F
`define KBT_PROGRAM_LOAD_KEY_CTRL 8'hED
// ----------------------------------------
// Timing
// ----------------------------------------
`define KBT_CLK_MHZ 100
`define KBT_TIMER_MS 1000
`define KBT_BEEP_MS 1000
`define KBT_CLICK_US 1000
`endif

// *** kbt_pkg.sv ***
// Types shared by the keyboard and interval timer port.
// Assumes nothing beyond the constants header.
package kbt_pkg;
  // Host I/O bus commands as decoded by the bus logic
  typedef enum logic [3:0] {
    KBT_CMD_SELECT, KBT_CMD_CLEAR, KBT_CMD_STATUS, KBT_CMD_INPUT, KBT_CMD_LIGHTS,
    KBT_CMD_BEEP, KBT_CMD_CLICK, KBT_CMD_TSTART, KBT_CMD_TCANCEL, KBT_CMD_PARITY
  } kbt_cmd_t;
  // Keyboard section of a key event
  typedef enum logic [1:0] {KBT_SEC_RAW, KBT_SEC_LETTER, KBT_SEC_CPAD, KBT_SEC_FKEY} kbt_sec_t;
  typedef struct packed {
    kbt_cmd_t cmd;
    logic [7:0] data;
  } kbt_bus_cmd_t;
  typedef struct packed {
    kbt_sec_t sec;
    logic shift;
    logic ctrl;
    logic [4:0] index;
    logic [7:0] raw;
  } kbt_key_t;
endpackage

// *** kbt_port.sv ***
// Keyboard and interval timer port: key FIFO, command decode, timer, tones.
// Assumes commands and key events arrive from logic on mclk_in.
// Function
// [RL1] Device commands act only while selected; select with code E1.
// [RL2] Clear drops pending keys, clears interrupt, available flag, timer, timeout.
// [RL3] Status byte: available bit 7, timeout bit 6, parity error bit 5.
// [RL4] Data input returns last key code, clears available flag and interrupt; here it pops the oldest queued code, clearing both only when the FIFO empties.
// [RL5] Light output bits 3..0 drive lamps of keys F3..F0.
// [RL6] Beep sounds one second tone even when not selected.
// [RL7] Click sounds short click even when not selected.
// [RL8] Timer start, when selected, times one second; expiry sets timeout.
// [RL9] Timer start while running restarts a full interval.
// [RL10] Timer cancel clears timer and timeout with its interrupt.
// [RL11] Lowest level interrupt on key available or timer expiry.
// [RL12] Timeout cleared by timer start, timer cancel or device clear.
// [RL13] Program-load key with shift and control forces boot at location 0.
// [RL14] Parity control bits: 7 irq enable, 6 even, 5 halt, 4 block display.
// [RL15] Letters give distinct lower, upper and control codes.
// [RL16] Control pad codes from 80, control equal, shifted 10 higher.
// [RL17] Status bits 4..0 read as zero.
`timescale 1ns/1ps
`include "kbt_consts.svh"

// ----------------------------------------
// Key code FIFO
// ----------------------------------------
module kbt_fifo
  import kbt_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic flush_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic push;
  logic pop;

  // Honest full and empty from pointers one bit wider than the address
  assign out_valid_out = (wr_q != rd_q);
  assign in_ready_out = (wr_q[AW-1:0] != rd_q[AW-1:0]) || (wr_q[AW] == rd_q[AW]);
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;
  assign out_data_out = mem[rd_q[AW-1:0]];

  // Storage has no reset; only pointers carry state
  always_ff @(posedge mclk_in) begin
    if (push) begin
      mem[wr_q[AW-1:0]] <= in_data_in;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_q <= '0;
    end else if (push) begin
      wr_q <= wr_q + 1'b1;
    end
  end

  // Flush keeps a word pushed in the same cycle, so no key is lost
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_q <= '0;
    end else if (flush_in) begin
      rd_q <= wr_q;
    end else if (pop) begin
      rd_q <= rd_q + 1'b1;
    end
  end
endmodule

// ----------------------------------------
// Port top
// ----------------------------------------
module kbt_port
  import kbt_pkg::*;
#(
  parameter int TIMER_CYCLES = `KBT_TIMER_MS * 1000 * `KBT_CLK_MHZ,
  parameter int BEEP_CYCLES = `KBT_BEEP_MS * 1000 * `KBT_CLK_MHZ,
  parameter int CLICK_CYCLES = `KBT_CLICK_US * `KBT_CLK_MHZ,
  parameter int FIFO_DEPTH = 32
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic cmd_valid_in,
  input wire kbt_bus_cmd_t cmd_in,
  output logic rd_valid_out,
  output logic [7:0] rd_data_out,
  input wire logic key_valid_in,
  output logic key_ready_out,
  input wire kbt_key_t key_in,
  input wire logic parity_err_in,
  output logic [3:0] lamps_out,
  output logic [3:0] parity_ctl_out,
  output logic beep_out,
  output logic click_out,
  output logic irq0_out,
  output logic boot_force_out
);
  typedef enum logic {KBT_T_IDLE, KBT_T_RUN} kbt_tstate_t;
  kbt_tstate_t tstate_q;
  logic sel_q;
  logic timeout_q;
  logic [31:0] tcnt_q;
  logic [31:0] beep_q;
  logic [31:0] click_q;
  logic [7:0] code;
  logic is_program_load_key;
  logic fifo_valid;
  logic fifo_ready;
  logic [7:0] fifo_data;
  logic acc;
  logic c_clear;
  logic c_input;
  logic c_start;
  logic c_cancel;
  logic expire;

  // Selected-only commands; beep and click bypass this gate
  assign acc = cmd_valid_in && sel_q; // RL1
  assign c_clear = acc && (cmd_in.cmd == KBT_CMD_CLEAR);
  assign c_input = acc && (cmd_in.cmd == KBT_CMD_INPUT);
  assign c_start = acc && (cmd_in.cmd == KBT_CMD_TSTART);
  assign c_cancel = acc && (cmd_in.cmd == KBT_CMD_TCANCEL);
  assign expire = (tstate_q == KBT_T_RUN) && (tcnt_q == 32'h0000_0001) && !c_start && !c_cancel
    && !c_clear;

  // Select register; any other select code deselects the port
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      sel_q <= 1'b0;
    end else if (cmd_valid_in && cmd_in.cmd == KBT_CMD_SELECT) begin
      sel_q <= (cmd_in.data == `KBT_SEL_CODE); // RL1
    end
  end

  // Key encoder; tables beyond these sections come in as raw codes
  always_comb begin
    code = key_in.raw;
    is_program_load_key = 1'b0;
    case (key_in.sec)
      KBT_SEC_LETTER: begin
        if (key_in.ctrl) begin
          code = `KBT_CTRL_BASE + {3'h0, key_in.index}; // RL15
        end else if (key_in.shift) begin
          code = `KBT_UPPER_BASE + {3'h0, key_in.index}; // RL15
        end else begin
          code = `KBT_LOWER_BASE + {3'h0, key_in.index}; // RL15
        end
      end
      KBT_SEC_CPAD: begin
        code = `KBT_CPAD_BASE + {4'h0, key_in.index[3:0]}
          + (key_in.shift ? `KBT_CPAD_SHIFT : 8'h00); // RL16
      end
      KBT_SEC_FKEY: begin
        code = `KBT_FKEY_BASE + {4'h0, key_in.index[3:0]} + (key_in.shift ? 8'h10 : 8'h00);
        if (key_in.index == `KBT_PROGRAM_LOAD_KEY_IDX && key_in.ctrl) begin
          code = `KBT_PROGRAM_LOAD_KEY_CTRL;
          is_program_load_key = key_in.shift; // RL13
        end
      end
      default: begin
        code = key_in.raw;
      end
    endcase
  end

  // Boot key never enters the FIFO, it drives the boot request instead
  kbt_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .flush_in(c_clear), // RL2
    .in_valid_in(key_valid_in && !is_program_load_key),
    .in_ready_out(fifo_ready),
    .in_data_in(code),
    .out_valid_out(fifo_valid),
    .out_ready_in(c_input), // RL4
    .out_data_out(fifo_data)
  );
  assign key_ready_out = fifo_ready || is_program_load_key;

  // Boot request pulse
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      boot_force_out <= 1'b0;
    end else begin
      boot_force_out <= key_valid_in && is_program_load_key; // RL13
    end
  end

  // Read answers one cycle after the command
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_valid_out <= 1'b0;
      rd_data_out <= 8'h00;
    end else begin
      rd_valid_out <= acc && (cmd_in.cmd == KBT_CMD_STATUS || cmd_in.cmd == KBT_CMD_INPUT);
      if (acc && cmd_in.cmd == KBT_CMD_STATUS) begin
        rd_data_out <= {fifo_valid, timeout_q, parity_err_in, 5'h00}; // RL3 RL17
      end else if (c_input) begin
        rd_data_out <= fifo_data; // RL4
      end
    end
  end

  // Lamp and parity control registers
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      lamps_out <= 4'h0;
      parity_ctl_out <= 4'h0;
    end else if (acc && cmd_in.cmd == KBT_CMD_LIGHTS) begin
      lamps_out <= cmd_in.data[3:0]; // RL5
    end else if (acc && cmd_in.cmd == KBT_CMD_PARITY) begin
      parity_ctl_out <= cmd_in.data[`KBT_PC_IRQ_EN:`KBT_PC_BLOCK_DISP]; // RL14
    end
  end

  // Interval timer; a start always reloads a full interval
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      tstate_q <= KBT_T_IDLE;
      tcnt_q <= 32'h0;
    end else if (c_start) begin
      tstate_q <= KBT_T_RUN; // RL8 RL9
      tcnt_q <= 32'(TIMER_CYCLES);
    end else if (c_cancel || c_clear || expire) begin
      tstate_q <= KBT_T_IDLE; // RL10 RL2
      tcnt_q <= 32'h0;
    end else begin
      case (tstate_q)
        KBT_T_RUN: tcnt_q <= tcnt_q - 32'h1;
        default: tcnt_q <= 32'h0;
      endcase
    end
  end

  // Timeout flag; expiry is blocked only by a command that also clears
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      timeout_q <= 1'b0;
    end else if (expire) begin
      timeout_q <= 1'b1; // RL8
    end else if (c_start || c_cancel || c_clear) begin
      timeout_q <= 1'b0; // RL12
    end
  end

  // Shared lowest-level request
  assign irq0_out = fifo_valid || timeout_q; // RL11

  // Tones run regardless of selection
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      beep_q <= 32'h0;
      click_q <= 32'h0;
    end else begin
      if (cmd_valid_in && cmd_in.cmd == KBT_CMD_BEEP) begin
        beep_q <= 32'(BEEP_CYCLES); // RL6
      end else if (beep_q != 32'h0) begin
        beep_q <= beep_q - 32'h1;
      end
      if (cmd_valid_in && cmd_in.cmd == KBT_CMD_CLICK) begin
        click_q <= 32'(CLICK_CYCLES); // RL7
      end else if (click_q != 32'h0) begin
        click_q <= click_q - 32'h1;
      end
    end
  end
  assign beep_out = (beep_q != 32'h0);
  assign click_out = (click_q != 32'h0);

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  sequence s_start;
    c_start;
  endsequence
  sequence s_run8;
    (tstate_q == KBT_T_RUN && !timeout_q)[*8];
  endsequence

  chk_sel_gate: assert property (cmd_valid_in && !sel_q && cmd_in.cmd == KBT_CMD_STATUS
    |=> !rd_valid_out) else $error("read answered while deselected"); // RL1
  chk_clear_flush: assert property (c_clear && !key_valid_in |=> !fifo_valid && !timeout_q)
    else $error("clear left key or timeout"); // RL2
  chk_status_byte: assert property (acc && cmd_in.cmd == KBT_CMD_STATUS
    |=> rd_valid_out && rd_data_out == {$past(fifo_valid), $past(timeout_q),
    $past(parity_err_in), 5'h00}) else $error("status byte wrong"); // RL3
  chk_input_data: assert property (c_input && fifo_valid
    |=> rd_data_out == $past(fifo_data)) else $error("input code wrong"); // RL4
  chk_lamp_set: assert property (acc && cmd_in.cmd == KBT_CMD_LIGHTS
    |=> lamps_out == $past(cmd_in.data[3:0])) else $error("lamps not set"); // RL5
  chk_beep_len: assert property (cmd_valid_in && cmd_in.cmd == KBT_CMD_BEEP
    |=> beep_out[*8]) else $error("beep too short"); // RL6
  chk_click_any: assert property (cmd_valid_in && cmd_in.cmd == KBT_CMD_CLICK
    |=> click_out) else $error("click missing"); // RL7
  chk_timer_run: assert property (s_start |=> s_run8 or (##[0:7] (c_cancel || c_clear)))
    else $error("timer not running"); // RL8 RL9
  chk_timer_expire: assert property (expire |=> timeout_q && irq0_out && tstate_q == KBT_T_IDLE)
    else $error("expiry not flagged"); // RL8 RL11
  chk_cancel_clr: assert property (c_cancel && !expire |=> !timeout_q)
    else $error("cancel kept timeout"); // RL10 RL12
  chk_boot_key: assert property (key_valid_in && key_in.sec == KBT_SEC_FKEY
    && key_in.index == `KBT_PROGRAM_LOAD_KEY_IDX && key_in.shift && key_in.ctrl |=> boot_force_out)
    else $error("boot not forced"); // RL13
endmodule

// *** kbt_host_model.sv ***
// Host side of the port: issues one bus command at a time.
// Assumes the port takes commands on the rising edge of mclk_in.
`timescale 1ns/1ps
// ----------------------------------------
// Host model
// ----------------------------------------
module kbt_host_model
  import kbt_pkg::*;
(
  input wire logic mclk_in,
  output logic cmd_valid_out,
  output kbt_bus_cmd_t cmd_out,
  input wire logic rd_valid_in,
  input wire logic [7:0] rd_data_in
);
  // Idle bus at time zero
  initial begin
    cmd_valid_out = 1'b0;
    cmd_out = '0;
  end
  // Strobe lasts one cycle; data is scrambled on release so stale bytes never look valid
  task automatic issue(input kbt_cmd_t c, input logic [7:0] d);
    @(posedge mclk_in);
    cmd_valid_out <= 1'b1;
    cmd_out <= '{cmd: c, data: d};
    @(posedge mclk_in);
    cmd_valid_out <= 1'b0;
    cmd_out <= '{cmd: c, data: ~d};
  endtask
  // Answer is registered on the taking edge and sampled 1 ns later; a missing answer reads unknown
  task automatic read(input kbt_cmd_t c, output logic [7:0] d);
    issue(c, 8'h00);
    #1;
    d = rd_valid_in ? rd_data_in : 8'hXX;
  endtask
endmodule

// *** kbt_port_tb.sv ***
// Self-checking bench for the keyboard and interval timer port.
// Assumes short timer and tone counts set by parameter below.
`timescale 1ns/1ps
`include "kbt_consts.svh"
// ----------------------------------------
// Bench top
// ----------------------------------------
module kbt_port_tb;
  import kbt_pkg::*;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic cmd_valid_in, rd_valid_out, key_ready_out, beep_out, click_out, irq0_out;
  logic boot_force_out, seen;
  logic key_valid_in = 1'b0;
  logic parity_err_in = 1'b0;
  kbt_bus_cmd_t cmd_in;
  kbt_key_t key_in = '0;
  kbt_key_t k;
  logic [7:0] rd_data_out, b, v;
  logic [3:0] lamps_out, parity_ctl_out;
  logic [7:0] q[$];
  int fails = 0;
  int num_checks = 0;
  always #5 mclk_in = ~mclk_in;
  kbt_port #(.TIMER_CYCLES(20), .BEEP_CYCLES(20), .CLICK_CYCLES(10)) i_kbt_port (
    .mclk_in, .rst_in, .cmd_valid_in, .cmd_in, .rd_valid_out, .rd_data_out, .key_valid_in,
    .key_ready_out, .key_in, .parity_err_in, .lamps_out, .parity_ctl_out, .beep_out,
    .click_out, .irq0_out, .boot_force_out);
  kbt_host_model i_kbt_host_model (.mclk_in, .cmd_valid_out(cmd_valid_in),
    .cmd_out(cmd_in), .rd_valid_in(rd_valid_out), .rd_data_in(rd_data_out));
  // Expected key code worked out from section, index and modifiers
  function automatic logic [7:0] code(input kbt_key_t x);
    if (x.sec == KBT_SEC_RAW) return x.raw;
    if (x.sec == KBT_SEC_FKEY) begin
      if (x.index == `KBT_PROGRAM_LOAD_KEY_IDX && x.ctrl) return `KBT_PROGRAM_LOAD_KEY_CTRL;
      return `KBT_FKEY_BASE + {3'h0, x.index} + (x.shift ? 8'h10 : 8'h00);
    end
    if (x.sec == KBT_SEC_CPAD)
      return `KBT_CPAD_BASE + {3'h0, x.index} + (x.shift ? `KBT_CPAD_SHIFT : 8'h00);
    if (x.ctrl) return `KBT_CTRL_BASE + {3'h0, x.index};
    return (x.shift ? `KBT_UPPER_BASE : `KBT_LOWER_BASE) + {3'h0, x.index};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic cmd(input kbt_cmd_t c, input logic [7:0] d);
    i_kbt_host_model.issue(c, d);
  endtask
  task automatic st(input logic [7:0] exp);
    i_kbt_host_model.read(KBT_CMD_STATUS, b);
    chk(b, exp, "status");
  endtask
  // Key is held until taken; a key refused forever is caught by the watchdog
  task automatic push(input kbt_key_t x);
    @(posedge mclk_in);
    key_valid_in <= 1'b1;
    key_in <= x;
    @(negedge mclk_in);
    while (!key_ready_out) @(negedge mclk_in);
    @(posedge mclk_in);
    key_valid_in <= 1'b0;
    key_in <= ~x;
    if (!(x.sec == KBT_SEC_FKEY && x.index == `KBT_PROGRAM_LOAD_KEY_IDX && x.shift && x.ctrl))
      q.push_back(code(x));
  endtask
  task automatic drain();
    while (q.size() > 0) begin
      i_kbt_host_model.read(KBT_CMD_INPUT, b);
      chk(b, q.pop_front(), "key code");
    end
    @(negedge mclk_in);
    chk({7'h0, irq0_out}, 8'h00, "irq after drain");
  endtask
  task automatic rkey();
    k = '0;
    k.sec = $urandom_range(1) ? KBT_SEC_CPAD : KBT_SEC_LETTER;
    k.index = 5'($urandom_range(k.sec == KBT_SEC_CPAD ? 11 : 25));
    k.shift = 1'($urandom_range(1));
    k.ctrl = 1'($urandom_range(1));
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Cuts a hang short well past the expected run length
  initial begin
    #50000;
    fails++;
    test_done();
  end
  initial begin
    void'($urandom(32'h9B29B3E2));
    repeat (20) @(posedge mclk_in);
    rst_in <= 1'b0;
    cmd(KBT_CMD_LIGHTS, 8'h0F);
    @(negedge mclk_in);
    chk({4'h0, lamps_out}, 8'h00, "unselected lamps");
    cmd(KBT_CMD_SELECT, `KBT_SEL_CODE);
    st(8'h00);
    for (int i = 0; i < 8; i++) begin
      v = 8'($urandom);
      cmd(KBT_CMD_LIGHTS, v);
      cmd(KBT_CMD_PARITY, v);
      @(negedge mclk_in);
      chk({4'h0, lamps_out}, {4'h0, v[3:0]}, "lamps");
      chk({4'h0, parity_ctl_out}, {4'h0, v[7:4]}, "parity ctl");
    end
    @(posedge mclk_in) parity_err_in <= 1'b1;
    st(8'h20);
    @(posedge mclk_in) parity_err_in <= 1'b0;
    // Boundary indices of both sections with every modifier mix
    for (int i = 0; i < 16; i++) begin
      k = '0;
      k.sec = i[3] ? KBT_SEC_CPAD : KBT_SEC_LETTER;
      k.index = i[2] ? (i[3] ? 5'h0B : 5'h19) : 5'h00;
      k.shift = i[1];
      k.ctrl = i[0];
      push(k);
      @(negedge mclk_in);
      chk({7'h0, irq0_out}, 8'h01, "key irq");
    end
    st(8'h80);
    drain();
    // Fill to depth; ready must then drop with no key offered
    for (int i = 0; i < 32; i++) begin
      rkey();
      push(k);
    end
    @(negedge mclk_in);
    chk(8'(q.size()), 8'h20, "fifo depth");
    chk({7'h0, key_ready_out}, 8'h00, "fifo full");
    drain();
    k = '0;
    k.sec = KBT_SEC_FKEY;
    k.index = `KBT_PROGRAM_LOAD_KEY_IDX;
    k.shift = 1'b1;
    k.ctrl = 1'b1;
    push(k);
    seen = 1'b0;
    repeat (3) begin
      #1 seen = seen | boot_force_out;
      @(posedge mclk_in);
    end
    chk({7'h0, seen}, 8'h01, "boot pulse");
    st(8'h00);
    // Function keys, the load key with control only, and a raw code all queue
    k = '0;
    k.sec = KBT_SEC_FKEY;
    k.index = 5'h03;
    k.shift = 1'b1;
    k.ctrl = 1'b1;
    push(k);
    k.index = `KBT_PROGRAM_LOAD_KEY_IDX;
    k.shift = 1'b0;
    push(k);
    k = '0;
    k.raw = 8'h0D;
    push(k);
    drain();
    rkey();
    push(k);
    cmd(KBT_CMD_TSTART, 8'h00);
    repeat (25) @(posedge mclk_in);
    st(8'hC0);
    cmd(KBT_CMD_CLEAR, 8'h00);
    st(8'h00);
    chk({7'h0, irq0_out}, 8'h00, "irq after clear");
    q.delete();
    cmd(KBT_CMD_TSTART, 8'h00);
    repeat (12) @(posedge mclk_in);
    cmd(KBT_CMD_TSTART, 8'h00);
    repeat (12) @(posedge mclk_in);
    st(8'h00);
    repeat (12) @(posedge mclk_in);
    st(8'h40);
    chk({7'h0, irq0_out}, 8'h01, "timer irq");
    cmd(KBT_CMD_TSTART, 8'h00);
    st(8'h00);
    repeat (25) @(posedge mclk_in);
    cmd(KBT_CMD_TCANCEL, 8'h00);
    st(8'h00);
    // Cancel in mid-interval must keep the timeout from ever rising
    cmd(KBT_CMD_TSTART, 8'h00);
    repeat (5) @(posedge mclk_in);
    cmd(KBT_CMD_TCANCEL, 8'h00);
    repeat (25) @(posedge mclk_in);
    st(8'h00);
    cmd(KBT_CMD_SELECT, 8'h00);
    cmd(KBT_CMD_LIGHTS, 8'h00);
    cmd(KBT_CMD_BEEP, 8'h00);
    cmd(KBT_CMD_CLICK, 8'h00);
    repeat (3) @(posedge mclk_in);
    @(negedge mclk_in);
    chk({6'h0, beep_out, click_out}, 8'h03, "tones");
    chk({4'h0, lamps_out}, {4'h0, v[3:0]}, "deselected lamps");
    repeat (10) @(posedge mclk_in);
    @(negedge mclk_in);
    chk({6'h0, beep_out, click_out}, 8'h02, "click ends");
    repeat (10) @(posedge mclk_in);
    @(negedge mclk_in);
    chk({7'h0, beep_out}, 8'h00, "beep ends");
    test_done();
  end
endmodule
